// [logic/lfspm_top.sv]
// Fast-start search, power loop and power monitor with APB registers
`timescale 1ns/100ps
`default_nettype none
module lfspm_top
    import lfspm_pkg::*;
#(
    parameter int DAC_W = 10,
    parameter int FRAC_W = 16,
    parameter int AVG_SH = 3,
    parameter int LUT_PERIOD = LUT_CYC
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog monitor pins
    input wire logic burst_on,
    input wire logic mpd_above,
    input wire logic [7:0] mpd_code,
    input wire logic [7:0] temp_raw,
    // Table fetch through the shared two-wire master
    output logic lut_req,
    output logic [7:0] lut_slave,
    output logic [7:0] lut_word,
    input wire logic lut_ack,
    input wire logic [7:0] lut_data,
    // Laser drive
    output logic [DAC_W-1:0] bias_code,
    output logic [7:0] mod_code,
    output logic tx_dc_sink,
    output logic mod_off,
    output logic mon_cmp_mode,
    output logic [1:0] mpd_range
);
    localparam int AW = DAC_W + FRAC_W;

    // Clamped add on the extended bias value
    function automatic logic [AW-1:0] clamp_add(input logic [AW-1:0] a,
        input logic signed [AW+1:0] d);
        logic signed [AW+1:0] s;
        s = $signed({2'b00, a}) + d;
        if (s < 0) begin
            clamp_add = '0;
        end else if (s > $signed({2'b00, {AW{1'b1}}})) begin
            clamp_add = {AW{1'b1}};
        end else begin
            clamp_add = s[AW-1:0];
        end
    endfunction

    // Registers
    logic [2:0] bias_mode;
    logic rec_en, trk_en;
    logic [1:0] rec_time, lvl, range_cfg;
    logic [7:0] fs_init, target, moddac, trk_entry;
    logic [5:0] decay;
    logic [3:0] iters, gain, mon_bw;
    // Internal state
    lfspm_fs_t fs_state;
    logic [AW-1:0] bias_acc, step;
    logic [3:0] n_iter;
    logic [1:0] rec_cnt;
    logic [1:0] it_tmr;
    logic exceeded, fs_done, range_ovr;
    logic [9:0] sync1, sync2;
    logic [7+AVG_SH:0] avg_sum;
    logic [AVG_SH-1:0] avg_cnt;
    logic [7:0] meas, meas_c, txpower;
    logic mon_tick;
    logic [31:0] lut_tmr;

    // Two-flop synchronisers for the analog pins other than temp_raw
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {burst_on, mpd_above, mpd_code};
            sync2 <= sync1;
        end
    end
    logic burst_s, above_s;
    logic [7:0] code_s;
    assign {burst_s, above_s, code_s} = sync2;

    // APB decode; slave answers in the first access cycle
    logic wr, wr_ctrl, wr_bias, known;
    assign wr = psel && penable && pready && pwrite;
    assign wr_ctrl = wr && paddr == REG_CTRL;
    assign wr_bias = wr && paddr == REG_BIAS;
    assign known = paddr == REG_CTRL || paddr == REG_FSTART ||
        paddr == REG_LOOP || paddr == REG_TARGET || paddr == REG_MOD ||
        paddr == REG_BIAS || paddr == REG_STATUS || paddr == REG_TRACK;

    // Levelling shift applies to amplitude and target alike
    function automatic logic [7:0] level_scale(input logic [7:0] v,
        input logic [1:0] code);
        level_scale = v >> (code[1] ? 2'h2 : {1'b0, code[0]});
    endfunction
    logic [7:0] mod_eff, target_eff;
    assign mod_eff = level_scale(moddac, lvl);
    assign target_eff = level_scale(target, lvl);

    // Read assembly
    logic [31:0] rd_ctrl, rd_word;
    assign rd_ctrl = 32'(bias_mode) | (32'(rec_en) << CTRL_REC) |
        (32'(rec_time) << CTRL_RTIME) | (32'(lvl) << CTRL_LVL) |
        (32'(range_cfg) << CTRL_RANGE) | (32'(trk_en) << CTRL_TRK);
    assign rd_word =
        paddr == REG_CTRL ? rd_ctrl :
        paddr == REG_FSTART ? 32'(fs_init) | (32'(decay) << FS_DECAY) |
            (32'(iters) << FS_ITERS) :
        paddr == REG_LOOP ? 32'(gain) | (32'(mon_bw) << LOOP_BW) :
        paddr == REG_TARGET ? 32'(target) :
        paddr == REG_MOD ? 32'(moddac) :
        paddr == REG_BIAS ? 32'(bias_code) :
        paddr == REG_STATUS ? 32'(txpower) |
            (32'(fs_state != FS_IDLE) << ST_BUSY) |
            (32'(range_ovr) << ST_OVR) | (32'(above_s) << ST_ABOVE) :
        paddr == REG_TRACK ? 32'(trk_entry) : 32'h0000_0000;

    // Bus handshake and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration registers; the enable bit set by a write beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_mode <= 3'h0;
            {rec_en, rec_time, lvl, range_cfg, trk_en} <= '0;
            fs_init <= INIT_RST;
            decay <= DECAY_RST;
            iters <= ITERS_RST;
            gain <= 4'h0;
            mon_bw <= BW_RST;
            target <= 8'h00;
            moddac <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                bias_mode <= pwdata[2:0];
                rec_en <= pwdata[CTRL_REC];
                rec_time <= pwdata[CTRL_RTIME +: 2];
                lvl <= pwdata[CTRL_LVL +: 2];
                range_cfg <= pwdata[CTRL_RANGE +: 2];
                trk_en <= pwdata[CTRL_TRK];
            end else if (fs_done) begin
                bias_mode[CTRL_FS] <= 1'b0;
            end
            if (wr && paddr == REG_FSTART) begin
                fs_init <= pwdata[7:0];
                decay <= pwdata[FS_DECAY +: DECAY_W];
                iters <= pwdata[FS_ITERS +: 4];
            end
            if (wr && paddr == REG_LOOP) begin
                gain <= pwdata[3:0];
                mon_bw <= pwdata[LOOP_BW +: 4];
            end
            if (wr && paddr == REG_TARGET) target <= pwdata[7:0];
            if (wr && paddr == REG_MOD) moddac <= pwdata[7:0];
        end
    end

    // Burst-gated averaging of monitor samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avg_sum <= '0;
            avg_cnt <= '0;
            meas <= 8'h00;
            mon_tick <= 1'b0;
        end else begin
            mon_tick <= 1'b0;
            if (burst_s) begin
                avg_cnt <= avg_cnt + 1'b1;
                if (&avg_cnt) begin
                    meas <= 8'((avg_sum + {{AVG_SH{1'b0}}, code_s}) >> AVG_SH);
                    avg_sum <= '0;
                    mon_tick <= 1'b1;
                end else begin
                    avg_sum <= avg_sum + {{AVG_SH{1'b0}}, code_s};
                end
            end
        end
    end

    // Range override on saturation, mirror gain from the configured code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_ovr <= 1'b0;
            mpd_range <= 2'h0;
        end else begin
            if (mon_tick && meas == MON_MAX) begin
                range_ovr <= 1'b1;
                mpd_range <= RANGE_WIDE;
            end else if (mon_tick && meas < RANGE_BACK) begin
                range_ovr <= 1'b0;
                mpd_range <= range_cfg;
            end else if (!range_ovr) begin
                mpd_range <= range_cfg;
            end
        end
    end

    // Periodic tracking table fetch; the timer is long so it is a parameter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lut_tmr <= 32'h0000_0000;
            lut_req <= 1'b0;
            lut_slave <= LUT_SLAVE;
            lut_word <= LUT_BASE;
            trk_entry <= TRACK_BIAS;
        end else begin
            lut_req <= 1'b0;
            if (lut_tmr == 32'(LUT_PERIOD - 1)) begin
                lut_tmr <= 32'h0000_0000;
                lut_req <= trk_en;
                lut_word <= LUT_BASE | {1'b0, temp_raw[7:1]};
            end else begin
                lut_tmr <= lut_tmr + 32'h0000_0001;
            end
            if (lut_ack) trk_entry <= lut_data;
        end
    end

    lfspm_track u_track (
        .pclk(pclk),
        .presetn(presetn),
        .en(trk_en),
        .meas(meas),
        .entry(trk_entry),
        .corr(meas_c)
    );

    lfspm_lpf u_lpf (
        .pclk(pclk),
        .presetn(presetn),
        .bw(mon_bw),
        .x(meas_c),
        .y(txpower)
    );

    // Fast-start step arithmetic
    logic [31:0] step_wide;
    logic [AW-1:0] step_init, step_dec, step_use;
    logic [AW+DECAY_W-1:0] dec_prod;
    logic it_tick, fs_go, last_iter;
    logic [1:0] rec_iters;
    // Product widened first; an 8-bit product would lose the step
    assign step_wide = {16'(fs_init) * 16'(mod_eff), 16'h0000} >> STEP_SH;
    assign step_init = AW'(step_wide >> (16 - FRAC_W));
    assign dec_prod = {{DECAY_W{1'b0}}, step} * {{AW{1'b0}}, decay};
    assign step_dec = dec_prod[AW+DECAY_SH-1:DECAY_SH];
    assign step_use = (exceeded || above_s) ? step_dec : step;
    assign it_tick = it_tmr == 2'(ITER_CYC - 1);
    assign fs_go = bias_mode[CTRL_FS] && bias_mode[CTRL_APC] && burst_s;
    assign last_iter = n_iter + 4'h1 >= iters;
    assign rec_iters = (rec_time > REC_MAX) ? REC_MAX : rec_time;

    // Loop error, scaled by the gain code
    logic signed [9:0] err;
    logic signed [AW+1:0] loop_d, fs_d;
    logic [4:0] gsh;
    assign err = $signed({2'b00, target_eff}) - $signed({2'b00, meas_c});
    assign gsh = {1'b0, gain} + 5'(FRAC_W - GAIN_BASE);
    assign loop_d = $signed({{(AW-8){err[9]}}, err}) <<< gsh;
    assign fs_d = above_s ? -$signed({2'b00, step_use}) :
        $signed({2'b00, step_use});

    // Bias: search, then loop; open loop only host writes reach it
    logic [AW-1:0] next_bias;
    assign next_bias =
        (fs_state == FS_RUN && it_tick) ? clamp_add(bias_acc, fs_d) :
        (fs_state == FS_IDLE && bias_mode[CTRL_APC] && mon_tick) ?
            clamp_add(bias_acc, loop_d) :
        wr_bias ? {pwdata[DAC_W-1:0], {FRAC_W{1'b0}}} : bias_acc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_acc <= '0;
        end else begin
            bias_acc <= next_bias;
        end
    end
    assign bias_code = bias_acc[AW-1:FRAC_W];

    // Fast-start sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_state <= FS_IDLE;
            step <= '0;
            n_iter <= 4'h0;
            rec_cnt <= 2'h0;
            it_tmr <= 2'h0;
            exceeded <= 1'b0;
            fs_done <= 1'b0;
            tx_dc_sink <= 1'b0;
            mon_cmp_mode <= 1'b0;
            mod_off <= 1'b0;
        end else begin
            fs_done <= 1'b0;
            it_tmr <= (fs_state == FS_IDLE || it_tick) ? 2'h0 : it_tmr + 2'h1;
            unique case (fs_state)
                FS_IDLE: begin
                    if (fs_go && iters == 4'h0) begin
                        fs_done <= 1'b1;
                    end else if (fs_go && !fs_done) begin
                        fs_state <= FS_RUN;
                        step <= step_init;
                        n_iter <= 4'h0;
                        exceeded <= 1'b0;
                        tx_dc_sink <= 1'b1;
                        mon_cmp_mode <= 1'b1;
                    end
                end
                FS_RUN: begin
                    if (it_tick) begin
                        step <= step_use;
                        exceeded <= exceeded || above_s;
                        n_iter <= n_iter + 4'h1;
                        if (last_iter) begin
                            tx_dc_sink <= 1'b0;
                            mon_cmp_mode <= 1'b0;
                            rec_cnt <= 2'h0;
                            if (rec_en && rec_iters != 2'h0) begin
                                fs_state <= FS_RECOV;
                                mod_off <= 1'b1;
                            end else begin
                                fs_state <= FS_IDLE;
                                fs_done <= 1'b1;
                            end
                        end
                    end
                end
                FS_RECOV: begin
                    if (it_tick) begin
                        rec_cnt <= rec_cnt + 2'h1;
                        if (rec_cnt + 2'h1 == rec_iters) begin
                            fs_state <= FS_IDLE;
                            mod_off <= 1'b0;
                            fs_done <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Amplitude register; levelled code drives the modulation DAC
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_code <= 8'h00;
        end else begin
            mod_code <= mod_eff;
        end
    end

    // Checks; a zero step cannot move bias, so it is left out
    a_dc_sink_run: assert property (@(posedge pclk)
        disable iff (!presetn)
        tx_dc_sink == (fs_state == FS_RUN) && mon_cmp_mode == tx_dc_sink)
        else $error("dc sink or compare mode out of step with search");
    a_step_start: assert property (@(posedge pclk)
        disable iff (!presetn) $rose(tx_dc_sink) |-> step == $past(step_init))
        else $error("initial step not loaded at search start");
    a_iter_time: assert property (@(posedge pclk)
        disable iff (!presetn)
        fs_state == FS_RUN && it_tick && !last_iter |=> !it_tick ##1 it_tick)
        else $error("iteration length wrong");
    a_bias_up: assert property (@(posedge pclk)
        disable iff (!presetn)
        fs_state == FS_RUN && it_tick && !above_s && step_use != '0 &&
        !(&bias_acc) |=> bias_acc > $past(bias_acc))
        else $error("bias did not rise below target");
    a_bias_down: assert property (@(posedge pclk)
        disable iff (!presetn)
        fs_state == FS_RUN && it_tick && above_s && step_use != '0 &&
        bias_acc != '0 |=> bias_acc < $past(bias_acc))
        else $error("bias did not fall above target");
    a_fs_stop: assert property (@(posedge pclk)
        disable iff (!presetn)
        fs_state == FS_RUN && it_tick && last_iter |=> fs_state != FS_RUN)
        else $error("search ran past its count");
    a_fs_clear: assert property (@(posedge pclk)
        disable iff (!presetn) fs_done && !wr_ctrl |=> !bias_mode[CTRL_FS])
        else $error("fast-start enable not cleared");
    a_range_wide: assert property (@(posedge pclk)
        disable iff (!presetn)
        mon_tick && meas == MON_MAX |=> mpd_range == RANGE_WIDE [*2])
        else $error("saturation did not select widest range");
    a_mute_rec: assert property (@(posedge pclk)
        disable iff (!presetn) fs_state == FS_RECOV |-> mod_off && !tx_dc_sink)
        else $error("modulation not muted during recovery");
endmodule
`default_nettype wire

// [logic/lfspm_pkg.sv]
// Shared constants for the laser fast-start and power monitor block
package lfspm_pkg;
    // Clock and timing
    localparam int PCLK_NS = 40;
    localparam int ITER_NS = 62;
    localparam int ITER_CYC = (ITER_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int LUT_PERIOD_MS = 10;
    localparam int LUT_CYC = LUT_PERIOD_MS * 1000000 / PCLK_NS;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FSTART = 8'h04;
    localparam logic [7:0] REG_LOOP = 8'h08;
    localparam logic [7:0] REG_TARGET = 8'h0c;
    localparam logic [7:0] REG_MOD = 8'h10;
    localparam logic [7:0] REG_BIAS = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_TRACK = 8'h1c;
    // Register field positions
    localparam int CTRL_LUT = 0;
    localparam int CTRL_FS = 1;
    localparam int CTRL_APC = 2;
    localparam int CTRL_REC = 3;
    localparam int CTRL_RTIME = 4;
    localparam int CTRL_LVL = 6;
    localparam int CTRL_RANGE = 8;
    localparam int CTRL_TRK = 10;
    localparam int FS_DECAY = 8;
    localparam int FS_ITERS = 16;
    localparam int LOOP_BW = 4;
    localparam int ST_BUSY = 8;
    localparam int ST_OVR = 9;
    localparam int ST_ABOVE = 10;
    // Reset values
    localparam logic [5:0] DECAY_RST = 6'h20;
    localparam logic [3:0] ITERS_RST = 4'hf;
    localparam logic [3:0] BW_RST = 4'hf;
    localparam logic [7:0] INIT_RST = 8'h80;
    // Arithmetic constants
    localparam int DECAY_W = 6;
    localparam int DECAY_SH = 6;
    localparam int STEP_SH = 8;
    localparam int GAIN_BASE = 15;
    localparam int FILT_MAX = 15;
    localparam logic [1:0] REC_MAX = 2'h2;
    localparam logic [1:0] RANGE_WIDE = 2'h2;
    localparam logic [7:0] RANGE_BACK = 8'h40;
    localparam logic [7:0] MON_MAX = 8'hff;
    localparam logic [3:0] BW_BYPASS = 4'hf;
    localparam logic [7:0] TRACK_BIAS = 8'h80;
    localparam logic [7:0] LUT_SLAVE = 8'ha8;
    localparam logic [7:0] LUT_BASE = 8'h80;
    // Fast-start sequencer states
    typedef enum logic [2:0] {
        FS_IDLE = 3'b001,
        FS_RUN = 3'b010,
        FS_RECOV = 3'b100
    } lfspm_fs_t;
endpackage

// [logic/lfspm_track.sv]
// Tracking-error correction multiplier for the photodiode measure
`timescale 1ns/100ps
`default_nettype none
module lfspm_track
    import lfspm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Measure in, factor, corrected measure out
    input wire logic en,
    input wire logic [7:0] meas,
    input wire logic [7:0] entry,
    output logic [7:0] corr
);
    // Factor is (128 + entry) / 256, so 00h is 0.5 and 80h is unity
    logic [16:0] prod;
    logic [8:0] scaled;
    assign prod = {9'h000, meas} * {8'h00, 1'b0, entry} + {1'b0, meas, 8'h00}
        - {1'b0, meas, 8'h00} + {2'h0, meas, 7'h00};
    assign scaled = prod[16:8];

    // Saturate rather than wrap above full scale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corr <= 8'h00;
        end else if (en) begin
            corr <= scaled[8] ? MON_MAX : scaled[7:0];
        end else begin
            corr <= meas;
        end
    end

    a_track_unity: assert property (@(posedge pclk)
        disable iff (!presetn)
        en && entry == TRACK_BIAS |=> corr == $past(meas))
        else $error("unity tracking entry altered the measure");
endmodule
`default_nettype wire

// [logic/lfspm_lpf.sv]
// First-order low-pass filter for reported power
`timescale 1ns/100ps
`default_nettype none
module lfspm_lpf
    import lfspm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Setting, sample in, filtered out
    input wire logic [3:0] bw,
    input wire logic [7:0] x,
    output logic [7:0] y
);
    // Accumulator keeps FILT_MAX fraction bits so slow settings still move
    logic [7+FILT_MAX:0] acc;
    logic signed [8+FILT_MAX:0] diff;
    logic [4:0] shift;
    logic [7+FILT_MAX:0] next_acc;
    assign diff = $signed({1'b0, x, {FILT_MAX{1'b0}}}) - $signed({1'b0, acc});
    assign shift = 5'(FILT_MAX) - {1'b0, bw};
    assign next_acc = (bw == BW_BYPASS) ? {x, {FILT_MAX{1'b0}}} :
        (7+FILT_MAX+1)'($signed({1'b0, acc}) + (diff >>> shift));

    // Filter state and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
            y <= 8'h00;
        end else begin
            acc <= next_acc;
            y <= next_acc[7+FILT_MAX:FILT_MAX];
        end
    end

    a_lpf_bypass: assert property (@(posedge pclk)
        disable iff (!presetn)
        bw == BW_BYPASS |=> y == $past(x))
        else $error("bypass setting did not pass the sample through");
endmodule
`default_nettype wire

// [verification/lfspm_laser_model.sv]
// Laser, photodiode and table store model for the bench
`timescale 1ns/100ps
`default_nettype none
module lfspm_laser_model (
    // Clock and drive in
    input wire logic pclk,
    input wire logic [9:0] bias_code,
    input wire logic lut_req,
    // Photodiode and table answer
    output logic mpd_above,
    output logic [7:0] mpd_code,
    output logic lut_ack,
    output logic [7:0] lut_data
);
    // Light rises with bias; threshold fixed at 100 LSB
    assign mpd_above = bias_code >= 10'h064;
    assign mpd_code = bias_code[9:2];
    // Answer a table fetch one cycle late, data changes after ack
    always_ff @(posedge pclk) begin
        lut_ack <= lut_req;
        lut_data <= lut_req ? 8'h90 : 8'h6f;
    end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Directed bench for the fast-start and power monitor block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import lfspm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, burst_on = 0, mpd_above, lut_req, lut_ack;
    logic [7:0] mpd_code, lut_slave, lut_word, lut_data, mod_code;
    logic [7:0] temp_raw = 8'h3c;
    logic [9:0] bias_code;
    logic tx_dc_sink, mod_off, mon_cmp_mode, err;
    logic [1:0] mpd_range;
    int n_mismatch = 0, checks_done = 0, n;
    lfspm_top #(.LUT_PERIOD(50)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .burst_on(burst_on), .mpd_above(mpd_above),
        .mpd_code(mpd_code), .temp_raw(temp_raw), .lut_req(lut_req),
        .lut_slave(lut_slave), .lut_word(lut_word), .lut_ack(lut_ack),
        .lut_data(lut_data), .bias_code(bias_code), .mod_code(mod_code),
        .tx_dc_sink(tx_dc_sink), .mod_off(mod_off),
        .mon_cmp_mode(mon_cmp_mode), .mpd_range(mpd_range));
    lfspm_laser_model laser (.pclk(pclk), .bias_code(bias_code),
        .lut_req(lut_req), .mpd_above(mpd_above), .mpd_code(mpd_code),
        .lut_ack(lut_ack), .lut_data(lut_data));
    // 25 MHz clock
    initial begin
        forever #20 pclk = ~pclk;
    end
    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; request held until pready is seen
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog well beyond the directed run
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        xfer(0, REG_FSTART, 0);
        chk("fstart reset", 32'h000f2080, rd);
        xfer(0, REG_LOOP, 0);
        chk("loop reset", 32'h000000f0, rd);
        xfer(0, 8'h20, 0);
        chk("unmapped err", 1, err);
        $display("test registers done");
        // Levelling codes scale the modulation amplitude
        xfer(1, REG_MOD, 32'h80);
        for (int i = 0; i < 4; i++) begin
            xfer(1, REG_CTRL, (i << CTRL_LVL) | ((i % 3) << CTRL_RANGE));
            repeat (3) @(posedge pclk);
            chk("mod_code", 8'h80 >> (i == 0 ? 0 : i == 1 ? 1 : 2),
                mod_code);
            chk("mpd_range", i % 3, mpd_range);
        end
        $display("test levelling done");
        // Search of 8 iterations with 1 iteration of mute
        xfer(1, REG_MOD, 32'h40);
        xfer(1, REG_FSTART, 32'h00082080);
        burst_on <= 1;
        xfer(1, REG_CTRL, 32'h1e);
        n = 0;
        while (tx_dc_sink !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        #1 chk("cmp mode", 1, mon_cmp_mode);
        // The cycle just seen high counts as the first
        n = 1;
        while (tx_dc_sink === 1'b1 && n < 50) begin
            @(posedge pclk);
            #1 n++;
        end
        chk("search cycles", 8 * ITER_CYC, n);
        // Steps of 32 up five times, then 16, 8, 4 down (comparator lags)
        chk("bias after search", 10'h084, bias_code);
        n = 0;
        while (mod_off === 1'b1 && n < 50) begin
            @(posedge pclk);
            #1 n++;
        end
        chk("mute cycles", 1 * ITER_CYC, n);
        repeat (4) @(posedge pclk);
        xfer(0, REG_CTRL, 0);
        chk("enable cleared", 0, rd[CTRL_FS]);
        $display("test fast-start done");
        // Open loop: tracking on, range 01, levelling x0.25, fixed bias
        xfer(1, REG_CTRL, 32'h580);
        xfer(1, REG_BIAS, 32'h100);
        repeat (120) @(posedge pclk);
        chk("lut slave", 8'ha8, lut_slave);
        chk("lut word", 8'h9e, lut_word);
        chk("range cfg", 1, mpd_range);
        xfer(0, REG_TRACK, 0);
        chk("track entry", 8'h90, rd);
        // Measure 40h times 272/256 is 44h; comparator above
        xfer(0, REG_STATUS, 0);
        chk("status", 32'h444, rd);
        xfer(0, REG_BIAS, 0);
        chk("bias kept", 32'h100, rd);
        // Saturate the monitor, then fall below 40h
        xfer(1, REG_BIAS, 32'h3fc);
        temp_raw <= 8'hf1;
        repeat (60) @(posedge pclk);
        chk("range forced", RANGE_WIDE, mpd_range);
        chk("lut word 2", 8'hf8, lut_word);
        xfer(1, REG_BIAS, 32'h0fc);
        repeat (24) @(posedge pclk);
        chk("range back", 1, mpd_range);
        $display("test tracking done");
        summarize();
    end
endmodule
`default_nettype wire
